// ### verilog/lpc_pkg.sv
// Package with register map, field layout and constants of the partner config registers
package lpc_pkg;
    // Printed offsets are not multiples of four: they are register indices
    localparam logic [7:0]  IDX_DATAPATH_CTRL   = 8'h33;
    localparam logic [7:0]  IDX_PARTNER_CAPS    = 8'h35;
    localparam logic [7:0]  IDX_PARTNER_IDENT   = 8'h37;
    localparam logic [7:0]  IDX_REMOTE_TARGET0  = 8'h39;
    localparam logic [7:0]  IDX_CAPS_SHADOW_A   = 8'h1E;
    localparam logic [7:0]  IDX_CAPS_SHADOW_B   = 8'h1F;
    localparam logic [7:0]  IDX_LOCAL_CTRL      = 8'h40;
    localparam logic [7:0]  IDX_STATUS          = 8'h41;
    localparam int          ADDR_LSB            = 2;
    localparam int          ADDR_W              = 12;

    // Field positions
    localparam int          CRC_EN_BIT          = 2;
    localparam int          CAP_FREEZE_BIT      = 7;
    localparam int          SELFTEST_BIT        = 5;
    localparam int          MULTIPORT_BIT       = 4;
    localparam int          IDENT_FREEZE_BIT    = 0;
    localparam int          PASSTHRU_BIT        = 6;
    localparam int          CAP_FIELD_W         = 6;

    // Reset values
    localparam logic [7:0]  RST_DATAPATH_CTRL   = 8'h04;
    localparam logic [7:0]  RST_PARTNER_CAPS    = 8'h00;
    localparam logic [6:0]  RST_PARTNER_IDENT   = 7'h2A; // Arbitrary neutral value
    localparam logic [7:0]  RST_REMOTE_TARGET0  = 8'h00;
    localparam logic [7:0]  RST_LOCAL_CTRL      = 8'h00;
    localparam logic [7:0]  RESERVED_MASK_CTRL  = 8'hF8;

    // Control sequence framing
    localparam int          CSEQ_DATA_BYTES     = 8;
    localparam logic [3:0]  CSEQ_LAST_DATA      = 4'h7;
    localparam logic [7:0]  CRC_POLY            = 8'h07;
    localparam logic [7:0]  CRC_INIT            = 8'hFF;

    localparam logic [6:0]  ALIAS_SLOT0_DEFAULT = 7'h00;

    typedef enum logic [2:0] {
        CS_IDLE = 3'b001,
        CS_DATA = 3'b010,
        CS_CRC  = 3'b100
    } lpc_cseq_state_t;
endpackage : lpc_pkg

// ### verilog/lpc_cseq_if.sv
// Interface carrying control-sequence bytes into the CRC framer
`timescale 1ns/10ps
interface lpc_cseq_if;
    logic       byteValid;
    logic [7:0] byteData;
    logic       crcEnable;
    logic       outValid;
    logic [7:0] outData;
    logic       outLast;
    logic       busy;
    modport master (output byteValid, output byteData, output crcEnable,
                    input outValid, input outData, input outLast, input busy);
    modport framer (input byteValid, input byteData, input crcEnable,
                    output outValid, output outData, output outLast, output busy);
endinterface : lpc_cseq_if

// ### verilog/lpc_cseq_framer.sv
// Control-sequence framer: passes eight bytes and optionally appends a CRC byte
`timescale 1ns/10ps
module lpc_cseq_framer
    import lpc_pkg::*;
(
    // Clock and reset
    input  wire logic   sysClk,
    input  wire logic   resetN,
    input  wire logic   clkEn,
    // Byte stream
    lpc_cseq_if.framer  cs
);
    lpc_cseq_state_t state;
    logic [3:0]      count;
    logic [7:0]      crc;
    logic            crcOn;

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_step

    assign cs.busy = (state == CS_CRC);

    always_ff @(posedge sysClk) begin
        if (!resetN) begin
            state       <= CS_IDLE;
            count       <= '0;
            crc         <= CRC_INIT;
            crcOn       <= 1'b0;
            cs.outValid <= 1'b0;
            cs.outData  <= '0;
            cs.outLast  <= 1'b0;
        end else if (clkEn) begin
            cs.outValid <= 1'b0;
            cs.outLast  <= 1'b0;
            case (state)
                CS_IDLE, CS_DATA: begin
                    if (cs.byteValid) begin
                        // Enable is latched at first byte so a sequence is framed consistently
                        if (state == CS_IDLE) begin
                            crcOn <= cs.crcEnable;
                        end
                        crc         <= crc_step((state == CS_IDLE) ? CRC_INIT : crc,
                                                cs.byteData);
                        cs.outValid <= 1'b1;
                        cs.outData  <= cs.byteData;
                        if (count == CSEQ_LAST_DATA) begin
                            count <= '0;
                            if ((state == CS_IDLE) ? cs.crcEnable : crcOn) begin
                                state <= CS_CRC;
                            end else begin
                                state      <= CS_IDLE;
                                cs.outLast <= 1'b1;
                            end
                        end else begin
                            count <= count + 4'h1;
                            state <= CS_DATA;
                        end
                    end
                end
                CS_CRC: begin
                    cs.outValid <= 1'b1; // Ninth byte
                    cs.outData  <= crc;
                    cs.outLast  <= 1'b1;
                    state       <= CS_IDLE;
                end
                default: state <= CS_IDLE;
            endcase
        end
    end
endmodule : lpc_cseq_framer

// ### verilog/lpc_config_regs.sv
// Partner configuration register bank with APB slave, remap and control-sequence path
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - CRC enable, set at reset, appends CRC to each sent control sequence.
// - CRC covers the first eight bytes and goes out as ninth byte.
// - Forward GPIO count: 00 none, 01 one, 10 two, 11 four; reset zero.
// - Capability freeze blocks automatic loading of partner capability fields.
// - Frozen capabilities take the value in shadow register A when the freeze is written.
// - Self-test request bit mirrors the partner's self-test request.
// - Multi-port flag: 0 single-port partner, 1 multi-port partner.
// - Four-bit field holds partner port number for multi-port partners.
// - Self-test, multi-port, port fields load when back channel link detected.
// - Seven-bit partner ident normally loads from back channel value.
// - Ident freeze stops automatic ident loading, keeping software value.
// - Transactions to alias slot zero get remote target address substituted.
// - Remote target address resets to zero; bit zero reserved read-only.
// - Local transactions pass only if pass-through enabled and decode matches.
module lpc_config_regs
    import lpc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic              clkEn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Back channel partner information
    input  wire logic              linkDetected,
    input  wire logic              rxCapValid,
    input  wire logic [5:0]        rxCapData,
    input  wire logic              rxIdentValid,
    input  wire logic [6:0]        rxIdentData,
    // Control sequence in and out
    input  wire logic              ctrlSeqByteValid,
    input  wire logic [7:0]        ctrlSeqByteData,
    output logic                   ctrlSeqOutValid,
    output logic      [7:0]        ctrlSeqOutData,
    output logic                   ctrlSeqOutLast,
    output logic                   ctrlSeqBusy,
    // Forwarded GPIO
    input  wire logic [3:0]        gpioIn,
    output logic      [3:0]        gpioFwd,
    output logic      [3:0]        gpioFwdEnable,
    // Local I2C transaction
    input  wire logic              i2cReqValid,
    input  wire logic [6:0]        i2cReqAddr,
    input  wire logic              i2cReqIsAlias0,
    input  wire logic              i2cReqDecodeMatch,
    output logic                   i2cFwdValid,
    output logic      [6:0]        i2cFwdAddr
);
    logic [7:0]  datapathCtrl;
    logic [7:0]  partnerCaps;
    logic [6:0]  partnerIdent;
    logic        identFreeze;
    logic [6:0]  remoteTarget0;
    logic [7:0]  capsShadowA;
    logic [7:0]  capsShadowB;
    logic [7:0]  localCtrl;
    logic        freezeSeen;
    logic        setupPhase;
    logic        wrStrobe;
    logic        validAddr;
    logic [7:0]  regIndex;
    logic [7:0]  readByte;
    logic [5:0]  next_caps;
    logic        wrDatapath;
    logic        wrCaps;
    logic        wrIdent;
    logic        wrTarget0;
    logic        wrShadowA;
    logic        wrShadowB;
    logic        wrLocal;
    logic [3:0]  laneMask;
    logic [3:0]  laneData;

    lpc_cseq_if  cseq ();

    function automatic logic [3:0] gpio_mask(input logic [1:0] sel);
        case (sel)
            2'b00:   gpio_mask = 4'h0;
            2'b01:   gpio_mask = 4'h1;
            2'b10:   gpio_mask = 4'h3;
            2'b11:   gpio_mask = 4'hF;
            default: gpio_mask = 4'h0;
        endcase
    endfunction : gpio_mask

    function automatic logic index_known(input logic [7:0] idx);
        index_known = (idx == IDX_DATAPATH_CTRL) || (idx == IDX_PARTNER_CAPS) ||
                      (idx == IDX_PARTNER_IDENT) || (idx == IDX_REMOTE_TARGET0) ||
                      (idx == IDX_CAPS_SHADOW_A) || (idx == IDX_CAPS_SHADOW_B) ||
                      (idx == IDX_LOCAL_CTRL)    || (idx == IDX_STATUS);
    endfunction : index_known

    // Bus decode; each access completes in the cycle after setup
    assign regIndex   = paddr[ADDR_LSB +: 8];
    // Upper bits must be clear so no register is aliased
    assign validAddr  = index_known(regIndex) && (paddr[ADDR_LSB-1:0] == '0)
                        && (paddr[ADDR_W-1:ADDR_LSB+8] == '0);
    assign setupPhase = psel && !penable && !pready;
    assign wrStrobe   = psel && penable && pready && pwrite && validAddr;

    // One write enable per register except the read-only status register
    assign wrDatapath = wrStrobe && (regIndex == IDX_DATAPATH_CTRL);
    assign wrCaps     = wrStrobe && (regIndex == IDX_PARTNER_CAPS);
    assign wrIdent    = wrStrobe && (regIndex == IDX_PARTNER_IDENT);
    assign wrTarget0  = wrStrobe && (regIndex == IDX_REMOTE_TARGET0);
    assign wrShadowA  = wrStrobe && (regIndex == IDX_CAPS_SHADOW_A);
    assign wrShadowB  = wrStrobe && (regIndex == IDX_CAPS_SHADOW_B);
    assign wrLocal    = wrStrobe && (regIndex == IDX_LOCAL_CTRL);

    always_comb begin
        case (regIndex)
            IDX_DATAPATH_CTRL:  readByte = datapathCtrl;
            IDX_PARTNER_CAPS:   readByte = partnerCaps;
            IDX_PARTNER_IDENT:  readByte = {partnerIdent, identFreeze};
            IDX_REMOTE_TARGET0: readByte = {remoteTarget0, 1'b0};
            IDX_CAPS_SHADOW_A:  readByte = capsShadowA;
            IDX_CAPS_SHADOW_B:  readByte = capsShadowB;
            IDX_LOCAL_CTRL:     readByte = localCtrl;
            IDX_STATUS:         readByte = {6'h00, ctrlSeqBusy, linkDetected};
            default:            readByte = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pready  <= setupPhase;
            pslverr <= setupPhase && !validAddr;
        end
    end

    // Read data is latched at setup and stands for the access cycle
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            prdata <= '0;
        end else if (clkEn && setupPhase) begin
            prdata <= (!pwrite && validAddr) ? {24'h000000, readByte} : '0;
        end
    end

    // Datapath control register
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            datapathCtrl <= RST_DATAPATH_CTRL;
        end else if (clkEn && wrDatapath) begin
            datapathCtrl <= pwdata[7:0];
        end
    end

    // Shadow registers that hold frozen capability values
    // Shadow B is plain storage; only shadow A feeds the fields
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            capsShadowA <= RST_PARTNER_CAPS;
            capsShadowB <= RST_PARTNER_CAPS;
        end else if (clkEn) begin
            if (wrShadowA) begin
                capsShadowA <= pwdata[7:0];
            end
            if (wrShadowB) begin
                capsShadowB <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            localCtrl <= RST_LOCAL_CTRL;
        end else if (clkEn && wrLocal) begin
            localCtrl <= pwdata[7:0];
        end
    end

    // Capability fields are self-test, multi-port and port number in the low six bits
    always_comb begin
        next_caps = partnerCaps[CAP_FIELD_W-1:0];
        // A software write wins over an auto-load in the same cycle
        if (wrCaps) begin
            next_caps = pwdata[CAP_FIELD_W-1:0];
        end else if (partnerCaps[CAP_FREEZE_BIT] && freezeSeen) begin
            next_caps = capsShadowA[CAP_FIELD_W-1:0];
        end else if (!partnerCaps[CAP_FREEZE_BIT] && linkDetected && rxCapValid) begin
            next_caps = rxCapData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            partnerCaps <= RST_PARTNER_CAPS;
            freezeSeen  <= 1'b0;
        end else if (clkEn) begin
            partnerCaps[CAP_FIELD_W-1:0] <= next_caps;
            // Shadow value is applied once, in the cycle after the freeze is written
            freezeSeen <= wrCaps && pwdata[CAP_FREEZE_BIT] && !partnerCaps[CAP_FREEZE_BIT];
            if (wrCaps) begin
                partnerCaps[7:CAP_FIELD_W] <= pwdata[7:CAP_FIELD_W];
            end
        end
    end

    // Partner ident with its own freeze
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            partnerIdent <= RST_PARTNER_IDENT;
        end else if (clkEn) begin
            if (wrIdent) begin
                partnerIdent <= pwdata[7:1];
            end else if (!identFreeze && linkDetected && rxIdentValid) begin
                partnerIdent <= rxIdentData;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            identFreeze <= 1'b0;
        end else if (clkEn && wrIdent) begin
            identFreeze <= pwdata[IDENT_FREEZE_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            remoteTarget0 <= RST_REMOTE_TARGET0[7:1];
        end else if (clkEn && wrTarget0) begin
            remoteTarget0 <= pwdata[7:1];
        end
    end

    // Forwarded GPIO lanes; lanes above the selected count stay low
    assign laneMask = gpio_mask(datapathCtrl[1:0]);
    for (genvar lane = 0; lane < $bits(gpioIn); lane++) begin : g_lane
        assign laneData[lane] = gpioIn[lane] & laneMask[lane];
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            gpioFwdEnable <= '0;
        end else if (clkEn) begin
            gpioFwdEnable <= laneMask;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            gpioFwd <= '0;
        end else if (clkEn) begin
            gpioFwd <= laneData;
        end
    end

    // I2C forwarding with alias remap
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            i2cFwdValid <= 1'b0;
        end else if (clkEn) begin
            i2cFwdValid <= i2cReqValid && localCtrl[PASSTHRU_BIT]
                           && i2cReqDecodeMatch;
        end
    end

    // Address is held between requests
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            i2cFwdAddr <= ALIAS_SLOT0_DEFAULT;
        end else if (clkEn && i2cReqValid) begin
            i2cFwdAddr <= i2cReqIsAlias0 ? remoteTarget0 : i2cReqAddr;
        end
    end

    assign cseq.byteValid = ctrlSeqByteValid;
    assign cseq.byteData  = ctrlSeqByteData;
    assign cseq.crcEnable = datapathCtrl[CRC_EN_BIT];

    lpc_cseq_framer lpc_cseq_framer_i (
        .sysClk (sys_clk),
        .resetN (reset_n),
        .clkEn  (clkEn),
        .cs     (cseq.framer)
    );

    assign ctrlSeqOutValid = cseq.outValid;
    assign ctrlSeqOutData  = cseq.outData;
    assign ctrlSeqOutLast  = cseq.outLast;
    assign ctrlSeqBusy     = cseq.busy;
endmodule : lpc_config_regs

// ### tb/lpc_partner_model.sv
// Back channel model of the companion deserializer
`timescale 1ns/10ps
module lpc_partner_model (
    // Clock
    input  wire logic sys_clk,
    // Back channel
    output logic       linkDetected,
    output logic       rxCapValid,
    output logic [5:0] rxCapData,
    output logic       rxIdentValid,
    output logic [6:0] rxIdentData
);
    initial begin
        linkDetected = 1'b0;
        rxCapValid = 1'b0;
        rxCapData = 6'h2A;
        rxIdentValid = 1'b0;
        rxIdentData = 7'h55;
    end
    task automatic set_link(input logic up);
        @(posedge sys_clk);
        linkDetected <= up;
    endtask : set_link
    task automatic send(input logic isCap, input logic [6:0] val);
        @(posedge sys_clk);
        rxCapValid <= isCap;
        rxIdentValid <= !isCap;
        rxCapData <= val[5:0];
        rxIdentData <= val;
        @(posedge sys_clk);
        rxCapValid <= 1'b0;
        rxIdentValid <= 1'b0;
        // Released lines flip so that a late capture shows up as a wrong value
        rxCapData <= ~val[5:0];
        rxIdentData <= ~val;
    endtask : send
endmodule : lpc_partner_model

// ### tb/lpc_config_regs_assertions.sv
// Port-level assertions for the partner config register bank
`timescale 1ns/10ps
module lpc_config_regs_checker (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        clkEn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Datapath
    input wire logic        ctrlSeqByteValid,
    input wire logic [7:0]  ctrlSeqByteData,
    input wire logic        ctrlSeqOutValid,
    input wire logic [7:0]  ctrlSeqOutData,
    input wire logic        ctrlSeqOutLast,
    input wire logic        ctrlSeqBusy,
    input wire logic [3:0]  gpioFwd,
    input wire logic [3:0]  gpioFwdEnable,
    input wire logic        i2cReqValid,
    input wire logic        i2cReqDecodeMatch,
    input wire logic        i2cFwdValid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_seq_echo;
        ctrlSeqByteValid && !ctrlSeqBusy && clkEn
            |=> ctrlSeqOutValid && ctrlSeqOutData == $past(ctrlSeqByteData);
    endproperty
    a_seq_echo: assert property (p_seq_echo) else $error("byte not echoed");
    property p_crc_last;
        $rose(ctrlSeqBusy) |-> ##[0:2] (ctrlSeqOutValid && ctrlSeqOutLast);
    endproperty
    a_crc_last: assert property (p_crc_last) else $error("no check byte");
    property p_gpio_off;
        (gpioFwd & ~gpioFwdEnable) == 4'h0;
    endproperty
    a_gpio_off: assert property (p_gpio_off) else $error("disabled lane driven");
    property p_gpio_code;
        gpioFwdEnable inside {4'h0, 4'h1, 4'h3, 4'hF};
    endproperty
    a_gpio_code: assert property (p_gpio_code) else $error("bad lane mask");
    property p_i2c_gate;
        i2cFwdValid |-> $past(i2cReqValid) && $past(i2cReqDecodeMatch);
    endproperty
    a_i2c_gate: assert property (p_i2c_gate) else $error("unmatched forward");
    property p_apb_ready;
        psel && !penable && clkEn |=> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("no ready");
    property p_ready_pulse;
        pready |-> psel && penable ##1 !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready misplaced");
    property p_err_zero;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error with data");
endmodule : lpc_config_regs_checker
bind lpc_config_regs lpc_config_regs_checker lpc_config_regs_checker_i (.sys_clk, .reset_n,
    .clkEn, .psel, .penable, .prdata, .pready, .pslverr, .ctrlSeqByteValid, .ctrlSeqByteData,
    .ctrlSeqOutValid, .ctrlSeqOutData, .ctrlSeqOutLast, .ctrlSeqBusy, .gpioFwd, .gpioFwdEnable,
    .i2cReqValid, .i2cReqDecodeMatch, .i2cFwdValid);

// ### tb/lpc_config_regs_test.sv
// Self-checking bench for the partner config register bank
`timescale 1ns/10ps
module lpc_config_regs_test import lpc_pkg::*;;
    logic sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, linkDetected, rxCapValid, rxIdentValid;
    logic [5:0] rxCapData;
    logic [6:0] rxIdentData, i2cFwdAddr, i2cReqAddr = 7'h0;
    logic ctrlSeqByteValid = 1'b0, ctrlSeqOutValid, ctrlSeqOutLast, ctrlSeqBusy;
    logic [7:0] ctrlSeqByteData = 8'h0, ctrlSeqOutData;
    logic [3:0] gpioIn = 4'hD, gpioFwd, gpioFwdEnable;
    logic i2cReqValid = 1'b0, i2cReqIsAlias0 = 1'b0, i2cReqDecodeMatch = 1'b0, i2cFwdValid;
    logic [8:0] outQ[$];
    logic clkEn = 1'b1;
    int failures = 0;
    int cmp_count = 0;
    always #12.5 sys_clk = ~sys_clk;
    lpc_config_regs lpc_config_regs_i (.sys_clk, .reset_n, .clkEn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .linkDetected, .rxCapValid,
        .rxCapData, .rxIdentValid, .rxIdentData, .ctrlSeqByteValid, .ctrlSeqByteData,
        .ctrlSeqOutValid, .ctrlSeqOutData, .ctrlSeqOutLast, .ctrlSeqBusy, .gpioIn, .gpioFwd,
        .gpioFwdEnable, .i2cReqValid, .i2cReqAddr, .i2cReqIsAlias0, .i2cReqDecodeMatch,
        .i2cFwdValid, .i2cFwdAddr);
    lpc_partner_model lpc_partner_model_i (.sys_clk, .linkDetected, .rxCapValid, .rxCapData,
        .rxIdentValid, .rxIdentData);
    always @(posedge sys_clk) begin
        if (ctrlSeqOutValid === 1'b1) begin
            outQ.push_back({ctrlSeqOutLast, ctrlSeqOutData});
        end
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk("pready timeout", 32'h1, 32'h0);
            end_sim();
        end
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, idx, wd, d, e);
    endtask : wr
    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp, input logic xErr = 1'b0);
        logic [31:0] d;
        logic e;
        apb(1'b0, idx, 8'h00, d, e);
        chk("prdata", {24'h0, exp}, d);
        chk("pslverr", {31'h0, xErr}, {31'h0, e});
    endtask : rchk
    task automatic i2c(input logic [6:0] a, input logic al, input logic m, input logic ev,
                       input logic [6:0] ea);
        @(posedge sys_clk);
        i2cReqValid <= 1'b1;
        i2cReqAddr <= a;
        i2cReqIsAlias0 <= al;
        i2cReqDecodeMatch <= m;
        @(posedge sys_clk);
        i2cReqValid <= 1'b0;
        i2cReqAddr <= ~a;
        @(posedge sys_clk);
        chk("i2cFwdValid", {31'h0, ev}, {31'h0, i2cFwdValid});
        if (ev) chk("i2cFwdAddr", {25'h0, ea}, {25'h0, i2cFwdAddr});
    endtask : i2c
    task automatic seq(input logic crcOn);
        logic [7:0] c, d;
        int n;
        c = CRC_INIT;
        outQ.delete();
        for (int i = 0; i < CSEQ_DATA_BYTES; i++) begin
            d = 8'h3C + 8'(i * 17);
            @(posedge sys_clk);
            ctrlSeqByteValid <= 1'b1;
            ctrlSeqByteData <= d;
            c = c ^ d;
            for (int j = 0; j < 8; j++) c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        @(posedge sys_clk);
        ctrlSeqByteValid <= 1'b0;
        ctrlSeqByteData <= ~d;
        n = 0;
        while (outQ.size() < (crcOn ? 9 : 8) && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        chk("seq count", crcOn ? 9 : 8, outQ.size());
        if (outQ.size() == (crcOn ? 9 : 8)) begin
            chk("seq byte 8", {23'h0, !crcOn, d}, {23'h0, outQ[7]});
            if (crcOn) chk("seq check byte", {23'h0, 1'b1, c}, {23'h0, outQ[8]});
        end
    endtask : seq
    initial begin
        logic [3:0] lanes [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        rchk(IDX_DATAPATH_CTRL, 8'h04);
        rchk(IDX_PARTNER_CAPS, 8'h00);
        rchk(IDX_PARTNER_IDENT, {RST_PARTNER_IDENT, 1'b0});
        rchk(IDX_REMOTE_TARGET0, 8'h00);
        wr(IDX_REMOTE_TARGET0, 8'hFF);
        rchk(IDX_REMOTE_TARGET0, 8'hFE);
        rchk(8'h3C, 8'h00, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_DATAPATH_CTRL, 8'h04 | 8'(i));
            repeat (2) @(posedge sys_clk);
            chk("gpioFwdEnable", {28'h0, lanes[i]}, {28'h0, gpioFwdEnable});
            chk("gpioFwd", {28'h0, lanes[i] & gpioIn}, {28'h0, gpioFwd});
        end
        lpc_partner_model_i.send(1'b1, 7'h35);
        rchk(IDX_PARTNER_CAPS, 8'h00);
        lpc_partner_model_i.set_link(1'b1);
        lpc_partner_model_i.send(1'b1, 7'h35);
        rchk(IDX_PARTNER_CAPS, 8'h35);
        wr(IDX_PARTNER_CAPS, 8'h0F);
        rchk(IDX_PARTNER_CAPS, 8'h0F);
        lpc_partner_model_i.send(1'b1, 7'h20);
        rchk(IDX_PARTNER_CAPS, 8'h20);
        clkEn <= 1'b0;
        lpc_partner_model_i.send(1'b1, 7'h0A);
        clkEn <= 1'b1;
        rchk(IDX_PARTNER_CAPS, 8'h20);
        rchk(IDX_STATUS, 8'h01);
        wr(IDX_CAPS_SHADOW_B, 8'h5A);
        rchk(IDX_CAPS_SHADOW_B, 8'h5A);
        wr(IDX_CAPS_SHADOW_A, 8'h12);
        wr(IDX_PARTNER_CAPS, 8'h80);
        rchk(IDX_PARTNER_CAPS, 8'h92);
        lpc_partner_model_i.send(1'b1, 7'h3F);
        rchk(IDX_PARTNER_CAPS, 8'h92);
        lpc_partner_model_i.send(1'b0, 7'h11);
        rchk(IDX_PARTNER_IDENT, 8'h22);
        wr(IDX_PARTNER_IDENT, 8'hAB);
        lpc_partner_model_i.send(1'b0, 7'h0F);
        rchk(IDX_PARTNER_IDENT, 8'hAB);
        wr(IDX_REMOTE_TARGET0, 8'hA0);
        wr(IDX_LOCAL_CTRL, 8'h40);
        i2c(7'h10, 1'b1, 1'b1, 1'b1, 7'h50);
        i2c(7'h22, 1'b0, 1'b1, 1'b1, 7'h22);
        i2c(7'h22, 1'b0, 1'b0, 1'b0, 7'h00);
        wr(IDX_LOCAL_CTRL, 8'h00);
        i2c(7'h22, 1'b0, 1'b1, 1'b0, 7'h00);
        wr(IDX_DATAPATH_CTRL, 8'h04);
        seq(1'b1);
        wr(IDX_DATAPATH_CTRL, 8'h00);
        seq(1'b0);
        end_sim();
    end
endmodule : lpc_config_regs_test
